// ---- include/tsid_map.svh ----
// constants of the task switch and interrupt dispatch block
// assumes byte addresses on a 32-bit memory port and a 24-word state block
// How it works
// - a state block holds registers, flags, pointer, three stack pairs, table selector, page base
// - the task register keeps the selector of the running task's state block
// - a call or jump naming a state block selector starts a task switch
// - save outgoing state, load task register, then fetch the new block's descriptor
// - load all registers from the new block, only then resume execution
// - a task gate acts like a call gate but points at a state block
// - wide mode performs no hardware task switch; block base comes from descriptor (here tr_base is written directly from tab_base)
// - wide block supplies stack pointers, interrupt stack pointers and bitmap offset
// - vectors come from hardware, controller or software and index the table
// - interrupt or trap gates enter like call gates; task gates switch tasks
// - the interrupt table is found by linear base, never as a segment
// - wide mode uses 16-byte interrupt descriptors; task gates there are refused
// - table registers hold base and limit; task register holds block base and size
// - in wide mode table and task registers keep 64-bit bases
// - wide mode offers a priority register gating external interrupt classes
// - call, interrupt and exception switches set nested flag; return examines and clears it
`ifndef TSID_MAP_SVH
`define TSID_MAP_SVH
`define TSB_WORDS      24
`define TSB_FLAGS      14
`define TSB_LDTSEL     22
`define TSB_RSP0_OFS   64'h0000_0000_0000_0004
`define TSB_IOMAP_OFS  64'h0000_0000_0000_0064
`define TSB_IOMAP_IDX  4'hF
`define FLAG_IF        9
`define FLAG_NT        14
`define DESC_TASK_GATE 4'h5
`define DESC_TSS_IDLE  4'h9
`define DESC_TSS_BUSY  4'hB
`define DESC_INT_GATE  4'hE
`define DESC_TRAP_GATE 4'hF
`define DESC_BYTES_N   64'h0000_0000_0000_0008
`define DESC_BYTES_W   64'h0000_0000_0000_0010
`endif

// ---- include/tsid_pkg.sv ----
// types of the task switch and interrupt dispatch block
// assumes tsid_map.svh on the include path
`default_nettype none
`include "tsid_map.svh"
package tsid_pkg;
  typedef enum logic [3:0] {S_IDLE = 4'h0, S_GD = 4'h1, S_GCHK = 4'h2, S_SAVE = 4'h3, S_LDSEL = 4'h4,
    S_LOAD = 4'h5, S_RESUME = 4'h6, S_ID = 4'h7, S_IDEC = 4'h8, S_STK = 4'h9, S_FAULT = 4'hA} tsid_state_e;
  typedef enum logic [1:0] {K_JMP = 2'h0, K_CALL = 2'h1, K_INT = 2'h2, K_IRET = 2'h3} tsid_kind_e;
  typedef enum logic [1:0] {SRC_HW = 2'h0, SRC_EXT = 2'h1, SRC_SW = 2'h2} tsid_src_e;
  typedef enum logic [2:0] {F_NONE = 3'h0, F_LIMIT = 3'h1, F_TYPE = 3'h2, F_WIDE_TS = 3'h3,
    F_WIDE_GATE = 3'h4} tsid_fault_e;
  typedef logic [`TSB_WORDS-1:0][31:0] tsid_ctx_t;
  typedef struct packed {
    tsid_state_e st;
    tsid_kind_e  kind;
    tsid_fault_e fcode;
    logic        wm, pre, hop, busy, taken, done, fault;
    logic [4:0]  cnt;
    logic [7:0]  vec;
    logic [3:0]  task_priority_value, stk_idx;
    logic [15:0] new_sel, link_sel, tr_sel, ldt_sel, gdt_lim, idt_lim, hnd_sel;
    logic [63:0] tr_base, gdt_base, idt_base, ldt_base, mem_addr, hnd_off, stk_val;
    logic [31:0] tr_lim, ldt_lim, d_lo, d_hi, d_ex, mem_wdata;
    logic        mem_req, mem_we, hnd_valid, hnd_trap, stk_valid, ctx_valid;
    tsid_ctx_t   ctx;
  } tsid_regs_s;
endpackage : tsid_pkg
`default_nettype wire

// ---- include/tsid_tab_if.sv ----
// descriptor words, decoded fields and table address terms
// assumes one core drives it and the two helpers answer combinationally
`timescale 1ns/1ps
`default_nettype none
interface tsid_tab_if;
  logic [31:0] d_lo, d_hi, d_ex, t_lim, dec_lim;
  logic [63:0] dec_base, gate_off, t_base, t_addr;
  logic [15:0] gate_sel;
  logic [12:0] t_idx;
  logic [3:0]  dec_type;
  logic [1:0]  t_word;
  logic        dec_present, t_wide, t_over;
  modport dec  (input d_lo, d_hi, d_ex, output dec_base, dec_lim, dec_type, dec_present, gate_sel, gate_off);
  modport calc (input t_base, t_lim, t_idx, t_wide, t_word, output t_addr, t_over);
  modport core (output d_lo, d_hi, d_ex, t_base, t_lim, t_idx, t_wide, t_word,
                input dec_base, dec_lim, dec_type, dec_present, gate_sel, gate_off, t_addr, t_over);
endinterface : tsid_tab_if
`default_nettype wire

// ---- design/tsid_desc_dec.sv ----
// splits a fetched descriptor into base, limit, type and gate target
// assumes the upper word is zero for narrow descriptors
`timescale 1ns/1ps
`default_nettype none
module tsid_desc_dec (
  tsid_tab_if.dec tab
);
  // segment and gate fields
  always_comb begin
    tab.dec_base    = {tab.d_ex, tab.d_hi[31:24], tab.d_hi[7:0], tab.d_lo[31:16]};
    tab.dec_lim     = {12'h000, tab.d_hi[19:16], tab.d_lo[15:0]};
    tab.dec_type    = tab.d_hi[11:8];
    tab.dec_present = tab.d_hi[15];
    tab.gate_sel    = tab.d_lo[31:16];
    tab.gate_off    = {tab.d_ex, tab.d_hi[31:16], tab.d_lo[15:0]};
  end
endmodule : tsid_desc_dec
`default_nettype wire

// ---- design/tsid_tab_addr.sv ----
// entry address and limit check for a descriptor table
// assumes the index is already scaled-free and limit is inclusive
`timescale 1ns/1ps
`default_nettype none
`include "tsid_map.svh"
module tsid_tab_addr
  import tsid_pkg::*;
(
  tsid_tab_if.calc tab
);
  logic [63:0] size;
  logic [63:0] ofs;
  // entry offset, word address, last byte against limit
  always_comb begin
    size       = tab.t_wide ? `DESC_BYTES_W : `DESC_BYTES_N;
    ofs        = {51'h0, tab.t_idx} * size;
    tab.t_addr = tab.t_base + ofs + {60'h0, tab.t_word, 2'b00};
    tab.t_over = (ofs + size - 64'h1) > {32'h0, tab.t_lim};
  end
endmodule : tsid_tab_addr
`default_nettype wire

// ---- design/tsid_core.sv ----
// task switch and interrupt dispatch sequencer with its table registers
// assumes all inputs come from logic on clk and memory answers with mem_ack
`timescale 1ns/1ps
`default_nettype none
`include "tsid_map.svh"
module tsid_core
  import tsid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wide_mode,
  input  wire logic        ts_req,
  input  wire logic        ts_call,
  input  wire logic [15:0] ts_sel,
  input  wire logic        iret_req,
  input  wire logic        int_valid,
  input  wire logic [1:0]  int_src,
  input  wire logic [7:0]  int_vec,
  input  wire logic        stk_req,
  input  wire logic [3:0]  stk_idx,
  input  wire logic        tab_wr,
  input  wire logic [1:0]  tab_which,
  input  wire logic [63:0] tab_base,
  input  wire logic [31:0] tab_lim,
  input  wire logic [15:0] tab_sel,
  input  wire logic        tpr_wr,
  input  wire logic [3:0]  tpr_wdata,
  input  wire tsid_ctx_t   ctx_save,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic [63:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic             busy,
  output logic             taken,
  output logic             done,
  output logic             fault,
  output logic [2:0]       fault_code,
  output logic [15:0]      tr_sel,
  output logic [63:0]      tr_base,
  output logic [31:0]      tr_lim,
  output logic [15:0]      ldt_sel,
  output logic [3:0]       task_priority_value,
  output logic             hnd_valid,
  output logic             hnd_trap,
  output logic [15:0]      hnd_sel,
  output logic [63:0]      hnd_off,
  output logic             stk_valid,
  output logic [63:0]      stk_val,
  output logic             ctx_valid,
  output tsid_ctx_t        ctx_load
);
  tsid_regs_s  r_reg;
  tsid_regs_s  r_next;
  logic        int_ok;
  logic [63:0] stk_ofs;
  tsid_tab_if  tab ();

  tsid_desc_dec u_dec (
    .tab (tab.dec)
  );
  tsid_tab_addr u_addr (
    .tab (tab.calc)
  );

  // table address terms: global table while fetching a block, else interrupt table
  assign tab.t_base = (r_reg.st == S_GD) ? r_reg.gdt_base : r_reg.idt_base;
  assign tab.t_lim  = (r_reg.st == S_GD) ? {16'h0, r_reg.gdt_lim} : {16'h0, r_reg.idt_lim};
  assign tab.t_idx  = (r_reg.st == S_GD) ? r_reg.new_sel[15:3] : {5'h00, r_reg.vec};
  assign tab.t_wide = (r_reg.st == S_ID) && r_reg.wm;
  assign tab.t_word = r_reg.cnt[1:0];
  assign tab.d_lo   = r_reg.d_lo;
  assign tab.d_hi   = r_reg.d_hi;
  assign tab.d_ex   = r_reg.d_ex;

  // next state of every register
  always_comb begin
    r_next           = r_reg;
    r_next.taken     = 1'b0;
    r_next.done      = 1'b0;
    r_next.fault     = 1'b0;
    r_next.hnd_valid = 1'b0;
    r_next.stk_valid = 1'b0;
    r_next.ctx_valid = 1'b0;
    // external vectors need the enable flag and, in wide mode, a class above the priority
    int_ok = (int_src != SRC_EXT) ||
             (ctx_save[`TSB_FLAGS][`FLAG_IF] && (!wide_mode || (int_vec[7:4] > r_reg.task_priority_value)));
    stk_ofs = (r_reg.stk_idx == `TSB_IOMAP_IDX) ? `TSB_IOMAP_OFS :
              `TSB_RSP0_OFS + {57'h0, r_reg.stk_idx + {3'h0, (r_reg.stk_idx >= 4'h3)}, 3'h0};
    case (r_reg.st)
      S_IDLE: begin
        r_next.cnt  = 5'h00;
        r_next.hop  = 1'b0;
        r_next.d_ex = 32'h0;
        r_next.wm   = wide_mode;
        if (tab_wr) begin
          // narrow mode keeps only the low 32 bits of a base
          case (tab_which)
            2'h0: begin
              r_next.gdt_base = wide_mode ? tab_base : {32'h0, tab_base[31:0]};
              r_next.gdt_lim  = tab_lim[15:0];
            end
            2'h1: begin
              r_next.idt_base = wide_mode ? tab_base : {32'h0, tab_base[31:0]};
              r_next.idt_lim  = tab_lim[15:0];
            end
            2'h2: begin
              r_next.ldt_sel  = tab_sel;
              r_next.ldt_base = wide_mode ? tab_base : {32'h0, tab_base[31:0]};
              r_next.ldt_lim  = tab_lim;
            end
            default: begin
              r_next.tr_sel  = tab_sel;
              r_next.tr_base = wide_mode ? tab_base : {32'h0, tab_base[31:0]};
              r_next.tr_lim  = tab_lim;
            end
          endcase
        end
        if (tpr_wr && wide_mode) begin
          r_next.task_priority_value = tpr_wdata;
        end
        // one request per idle cycle: vector, switch, return, stack lookup
        if (int_valid && int_ok) begin
          r_next.taken = 1'b1;
          r_next.kind  = K_INT;
          r_next.vec   = int_vec;
          r_next.st    = S_ID;
        end else if (ts_req) begin
          r_next.taken   = 1'b1;
          r_next.kind    = ts_call ? K_CALL : K_JMP;
          r_next.new_sel = ts_sel;
          if (wide_mode) begin
            r_next.fcode = F_WIDE_TS;
            r_next.st    = S_FAULT;
          end else begin
            r_next.pre = 1'b1;
            r_next.st  = S_GD;
          end
        end else if (iret_req) begin
          r_next.taken = 1'b1;
          r_next.kind  = K_IRET;
          if (!wide_mode && ctx_save[`TSB_FLAGS][`FLAG_NT]) begin
            r_next.new_sel = r_reg.link_sel;
            r_next.pre     = 1'b1;
            r_next.hop     = 1'b1;
            r_next.st      = S_GD;
          end else begin
            r_next.done = 1'b1;
          end
        end else if (stk_req) begin
          r_next.taken   = 1'b1;
          r_next.stk_idx = stk_idx;
          if (wide_mode) begin
            r_next.st = S_STK;
          end else begin
            r_next.fcode = F_TYPE;
            r_next.st    = S_FAULT;
          end
        end
      end
      S_GD: begin
        // two words of a block or gate descriptor from the global table
        if (!r_reg.mem_req) begin
          if (tab.t_over) begin
            r_next.fcode = F_LIMIT;
            r_next.st    = S_FAULT;
          end else begin
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b0;
            r_next.mem_addr = tab.t_addr;
          end
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.cnt     = r_reg.cnt + 5'h01;
          if (r_reg.cnt == 5'h00) begin
            r_next.d_lo = mem_rdata;
          end else begin
            r_next.d_hi = mem_rdata;
            r_next.st   = S_GCHK;
          end
        end
      end
      S_GCHK: begin
        r_next.cnt = 5'h00;
        if (!tab.dec_present) begin
          r_next.fcode = F_TYPE;
          r_next.st    = S_FAULT;
        end else if (r_reg.pre) begin
          if (tab.dec_type == `DESC_TASK_GATE && !r_reg.hop) begin
            r_next.new_sel = tab.gate_sel;
            r_next.hop     = 1'b1;
            r_next.st      = S_GD;
          end else if (tab.dec_type == `DESC_TSS_IDLE || tab.dec_type == `DESC_TSS_BUSY) begin
            r_next.pre = 1'b0;
            r_next.st  = S_SAVE;
          end else begin
            r_next.fcode = F_TYPE;
            r_next.st    = S_FAULT;
          end
        end else begin
          r_next.tr_base = tab.dec_base;
          r_next.tr_lim  = tab.dec_lim;
          r_next.st      = S_LOAD;
        end
      end
      S_SAVE: begin
        // outgoing state into the current block, a return clears the nested flag
        if (!r_reg.mem_req) begin
          r_next.mem_req   = 1'b1;
          r_next.mem_we    = 1'b1;
          r_next.mem_addr  = r_reg.tr_base + {57'h0, r_reg.cnt, 2'b00};
          r_next.mem_wdata = ctx_save[r_reg.cnt];
          if (r_reg.cnt == 5'(`TSB_FLAGS) && r_reg.kind == K_IRET) begin
            r_next.mem_wdata[`FLAG_NT] = 1'b0;
          end
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.mem_we  = 1'b0;
          r_next.cnt     = r_reg.cnt + 5'h01;
          if (r_reg.cnt == 5'(`TSB_WORDS - 1)) begin
            r_next.cnt = 5'h00;
            r_next.st  = S_LDSEL;
          end
        end
      end
      S_LDSEL: begin
        r_next.tr_sel = r_reg.new_sel;
        if (r_reg.kind == K_CALL || r_reg.kind == K_INT) begin
          r_next.link_sel = r_reg.tr_sel;
        end
        r_next.st = S_GD;
      end
      S_LOAD: begin
        // incoming state from the new block, word by word
        if (!r_reg.mem_req) begin
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_addr = r_reg.tr_base + {57'h0, r_reg.cnt, 2'b00};
        end else if (mem_ack) begin
          r_next.mem_req        = 1'b0;
          r_next.ctx[r_reg.cnt] = mem_rdata;
          r_next.cnt            = r_reg.cnt + 5'h01;
          if (r_reg.cnt == 5'(`TSB_WORDS - 1)) begin
            r_next.st = S_RESUME;
          end
        end
      end
      S_RESUME: begin
        r_next.ldt_sel   = r_reg.ctx[`TSB_LDTSEL][15:0];
        r_next.ctx_valid = 1'b1;
        r_next.done      = 1'b1;
        if (r_reg.kind == K_CALL || r_reg.kind == K_INT) begin
          r_next.ctx[`TSB_FLAGS][`FLAG_NT] = 1'b1;
        end
        r_next.st = S_IDLE;
      end
      S_ID: begin
        // two words narrow, three wide (upper offset word)
        if (!r_reg.mem_req) begin
          if (tab.t_over) begin
            r_next.fcode = F_LIMIT;
            r_next.st    = S_FAULT;
          end else begin
            r_next.mem_req  = 1'b1;
            r_next.mem_we   = 1'b0;
            r_next.mem_addr = tab.t_addr;
          end
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.cnt     = r_reg.cnt + 5'h01;
          case (r_reg.cnt)
            5'h00:   r_next.d_lo = mem_rdata;
            5'h01:   r_next.d_hi = mem_rdata;
            default: r_next.d_ex = mem_rdata;
          endcase
          if (r_reg.cnt == (r_reg.wm ? 5'h02 : 5'h01)) begin
            r_next.st = S_IDEC;
          end
        end
      end
      S_IDEC: begin
        r_next.cnt = 5'h00;
        if (!tab.dec_present) begin
          r_next.fcode = F_TYPE;
          r_next.st    = S_FAULT;
        end else if (tab.dec_type == `DESC_INT_GATE || tab.dec_type == `DESC_TRAP_GATE) begin
          r_next.hnd_valid = 1'b1;
          r_next.hnd_trap  = (tab.dec_type == `DESC_TRAP_GATE);
          r_next.hnd_sel   = tab.gate_sel;
          r_next.hnd_off   = tab.gate_off;
          r_next.done      = 1'b1;
          r_next.st        = S_IDLE;
        end else if (tab.dec_type == `DESC_TASK_GATE && !r_reg.wm) begin
          r_next.new_sel = tab.gate_sel;
          r_next.pre     = 1'b1;
          r_next.hop     = 1'b1;
          r_next.st      = S_GD;
        end else begin
          r_next.fcode = r_reg.wm ? F_WIDE_GATE : F_TYPE;
          r_next.st    = S_FAULT;
        end
      end
      S_STK: begin
        // wide block lookup: stack pointer, interrupt stack pointer or bitmap offset
        if (!r_reg.mem_req) begin
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_addr = r_reg.tr_base + stk_ofs + {57'h0, r_reg.cnt, 2'b00};
        end else if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.cnt     = r_reg.cnt + 5'h01;
          if (r_reg.stk_idx == `TSB_IOMAP_IDX) begin
            r_next.stk_val   = {48'h0, mem_rdata[31:16]};
            r_next.stk_valid = 1'b1;
            r_next.done      = 1'b1;
            r_next.st        = S_IDLE;
          end else if (r_reg.cnt == 5'h00) begin
            r_next.stk_val[31:0] = mem_rdata;
          end else begin
            r_next.stk_val[63:32] = mem_rdata;
            r_next.stk_valid      = 1'b1;
            r_next.done           = 1'b1;
            r_next.st             = S_IDLE;
          end
        end
      end
      S_FAULT: begin
        r_next.fault   = 1'b1;
        r_next.mem_req = 1'b0;
        r_next.mem_we  = 1'b0;
        r_next.st      = S_IDLE;
      end
      default: r_next.st = S_IDLE;
    endcase
    r_next.busy = (r_next.st != S_IDLE);
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign mem_req    = r_reg.mem_req;
  assign mem_we     = r_reg.mem_we;
  assign mem_addr   = r_reg.mem_addr;
  assign mem_wdata  = r_reg.mem_wdata;
  assign busy       = r_reg.busy;
  assign taken      = r_reg.taken;
  assign done       = r_reg.done;
  assign fault      = r_reg.fault;
  assign fault_code = r_reg.fcode;
  assign tr_sel     = r_reg.tr_sel;
  assign tr_base    = r_reg.tr_base;
  assign tr_lim     = r_reg.tr_lim;
  assign ldt_sel    = r_reg.ldt_sel;
  assign task_priority_value        = r_reg.task_priority_value;
  assign hnd_valid  = r_reg.hnd_valid;
  assign hnd_trap   = r_reg.hnd_trap;
  assign hnd_sel    = r_reg.hnd_sel;
  assign hnd_off    = r_reg.hnd_off;
  assign stk_valid  = r_reg.stk_valid;
  assign stk_val    = r_reg.stk_val;
  assign ctx_valid  = r_reg.ctx_valid;
  assign ctx_load   = r_reg.ctx;

  // checks next to the sequencer
  a_tr_after_save: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.st == S_LDSEL) |=> (r_reg.tr_sel == $past(r_reg.new_sel)) && (r_reg.st == S_GD))
    else $error("task register not loaded after save");
  a_resume_last: assert property (@(posedge clk) disable iff (!reset_n)
    r_reg.ctx_valid |-> $past(r_reg.st == S_RESUME) && (r_reg.st == S_IDLE))
    else $error("new task resumed before its state was loaded");
  a_wide_no_save: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.st == S_SAVE) |-> !r_reg.wm)
    else $error("task switch in wide mode");
  a_nested_set: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.ctx_valid && (r_reg.kind == K_CALL || r_reg.kind == K_INT)) |-> r_reg.ctx[`TSB_FLAGS][`FLAG_NT])
    else $error("nested flag not set on call switch");
  a_idt_entry_addr: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.st == S_ID && r_reg.mem_req) |->
    r_reg.mem_addr == r_reg.idt_base + ({56'h0, r_reg.vec} << (r_reg.wm ? 4 : 3)) + {57'h0, r_reg.cnt, 2'b00})
    else $error("interrupt descriptor address wrong");
  a_save_addr: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.st == S_SAVE && r_reg.mem_req) |-> r_reg.mem_we && (r_reg.mem_addr == r_reg.tr_base + {57'h0, r_reg.cnt, 2'b00}))
    else $error("state save address wrong");
  a_tpr_write: assert property (@(posedge clk) disable iff (!reset_n)
    (tpr_wr && wide_mode && r_reg.st == S_IDLE) |=> (r_reg.task_priority_value == $past(tpr_wdata)))
    else $error("priority value not written");
  a_mem_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.mem_req && !mem_ack) |=> r_reg.mem_req && $stable(r_reg.mem_addr) && $stable(r_reg.mem_we))
    else $error("memory request dropped before acknowledge");
  a_ext_class: assert property (@(posedge clk) disable iff (!reset_n)
    (r_reg.st == S_IDLE && int_valid && int_src == SRC_EXT && wide_mode && int_vec[7:4] <= r_reg.task_priority_value)
    |=> !(r_reg.taken && r_reg.kind == K_INT))
    else $error("external interrupt below priority taken");
endmodule : tsid_core
`default_nettype wire

// ---- test/tsid_mem_model.sv ----
// word memory standing behind the core's memory port
// assumes one request at a time; answers one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module tsid_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [63:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] m [logic [63:0]];
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // answer each held request once; data line toggles while idle
  always @(posedge clk) begin
    if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      if (mem_we) m[mem_addr] = mem_wdata;
      mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : tsid_mem_model
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the task switch and dispatch core
// assumes the memory model answers every word access
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tsid_pkg::*;
  logic        clk, reset_n, wide_mode, ts_req, ts_call, iret_req, int_valid, stk_req, tab_wr, tpr_wr, mem_ack;
  logic        mem_req, mem_we, busy, taken, done, fault, hnd_valid, hnd_trap, stk_valid, ctx_valid;
  logic [1:0]  int_src, tab_which;
  logic [2:0]  fault_code;
  logic [3:0]  stk_idx, tpr_wdata, task_priority_value;
  logic [7:0]  int_vec;
  logic [15:0] ts_sel, tab_sel, tr_sel, ldt_sel, hnd_sel;
  logic [31:0] tab_lim, mem_rdata, mem_wdata, tr_lim;
  logic [63:0] tab_base, mem_addr, tr_base, hnd_off, stk_val;
  tsid_ctx_t   ctx_save, ctx_load;
  int          num_errors, n_compared;
  tsid_core i_tsid_core (.*);
  tsid_mem_model i_tsid_mem_model (.*);
  // clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // release requests once taken, then wait for the end pulse
  task automatic run;
    int k;
    @(posedge clk);
    {int_valid, ts_req, iret_req, stk_req} <= 4'h0;
    for (k = 0; k < 3000 && done !== 1'b1 && fault !== 1'b1; k++) @(posedge clk);
    if (k == 3000) begin
      num_errors++;
      $display("MISMATCH %0t operation timed out", $time);
    end
  endtask : run
  task automatic tab(input logic [1:0] w, input logic [63:0] b, input logic [31:0] l, input logic [15:0] s);
    @(posedge clk);
    {tab_wr, tab_which, tab_base, tab_lim, tab_sel} <= {1'b1, w, b, l, s};
    @(posedge clk);
    tab_wr <= 1'b0;
  endtask : tab
  task automatic intr(input logic [1:0] s);
    @(posedge clk);
    {int_valid, int_src, int_vec} <= {1'b1, s, 8'h21};
    run;
  endtask : intr
  // watchdog
  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report;
  end
  // main sequence
  initial begin
    {reset_n, wide_mode, ts_req, ts_call, iret_req, int_valid, stk_req, tab_wr, tpr_wr} = 9'h0;
    {int_src, tab_which, stk_idx, tpr_wdata, int_vec, ts_sel, tab_sel, tab_lim, tab_base} = '0;
    for (int i = 0; i < 24; i++) ctx_save[i] = 32'hA000 + i;
    ctx_save[14] = 32'h0200;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tab(2'h1, 64'h1000, 32'h7FF, 16'h0);
    for (int s = 0; s < 3; s++) begin
      i_tsid_mem_model.m[64'h1108] = 32'h0010_5678;
      i_tsid_mem_model.m[64'h110C] = (s == 1) ? 32'h1234_8F00 : 32'h1234_8E00;
      intr(s[1:0]);
      chk(hnd_sel, 16'h0010, "gate sel");
      chk(hnd_off, 64'h1234_5678, "gate off");
      chk(hnd_trap, s == 1, "gate kind");
    end
    $display("narrow gates finished");
    tab(2'h0, 64'h2000, 32'hFFF, 16'h0);
    tab(2'h3, 64'h3000, 32'h67, 16'h0008);
    i_tsid_mem_model.m[64'h2010] = 32'h4000_0067;
    i_tsid_mem_model.m[64'h2014] = 32'h0000_8900;
    i_tsid_mem_model.m[64'h2008] = 32'h3000_0067;
    i_tsid_mem_model.m[64'h200C] = 32'h0000_8B00;
    for (int i = 0; i < 24; i++) i_tsid_mem_model.m[64'h4000 + 4 * i] = 32'h100 + i;
    @(posedge clk);
    {ts_req, ts_call, ts_sel} <= {2'b11, 16'h0010};
    run;
    chk(tr_sel, 16'h0010, "task reg");
    chk(tr_base, 64'h4000, "task base");
    chk(i_tsid_mem_model.m[64'h303C], 32'hA00F, "saved ip");
    chk(ctx_load[3], 32'h103, "loaded reg");
    chk(ctx_load[14], 32'h410E, "nested set");
    chk(ldt_sel, 16'h0116, "local sel");
    ctx_save[14] = 32'h4200;
    @(posedge clk);
    iret_req <= 1'b1;
    run;
    chk(tr_sel, 16'h0008, "return link");
    $display("task switch finished");
    wide_mode <= 1'b1;
    @(posedge clk);
    {tpr_wr, tpr_wdata} <= 5'h11;
    @(posedge clk);
    tpr_wr <= 1'b0;
    @(posedge clk);
    chk(task_priority_value, 4'h1, "priority");
    {int_valid, int_src, int_vec} <= {1'b1, 2'h1, 8'h11};
    repeat (3) @(posedge clk);
    chk(busy, 1'b0, "class refused");
    int_valid <= 1'b0;
    i_tsid_mem_model.m[64'h1210] = 32'h0010_5678;
    i_tsid_mem_model.m[64'h1214] = 32'h1234_8E00;
    i_tsid_mem_model.m[64'h1218] = 32'h0000_0001;
    intr(2'h1);
    chk(hnd_off, 64'h1_1234_5678, "wide off");
    i_tsid_mem_model.m[64'h1214] = 32'h0000_8500;
    intr(2'h2);
    chk(fault_code, 3'h4, "wide task gate");
    @(posedge clk);
    ts_req <= 1'b1;
    run;
    chk(fault_code, 3'h3, "wide switch");
    i_tsid_mem_model.m[64'h3004] = 32'h89AB_CDEF;
    i_tsid_mem_model.m[64'h3008] = 32'h0000_0007;
    @(posedge clk);
    {stk_req, stk_idx} <= 5'h10;
    run;
    chk(stk_val, 64'h7_89AB_CDEF, "stack ptr");
    $display("wide mode finished");
    final_report;
  end
endmodule : tb
`default_nettype wire
